// File: design/touch_conv_ctrl.sv
// conversion-mode controller: idle, single, slave and master sequences
// assumes an external SAR core driven by conv_start/conv_done and a
// register port owned by a serial front end; all inputs synchronous to clk
//
// Contract
// [R1] mode 00 performs no conversion
// [R2] decode 01 single, 10 slave, 11 master
// [R3] single mode converts the selected channel
// [R4] single done, timer zero: mode to 00
// [R5] timer nonzero: repeat single at expiry
// [R6] writing 10 starts slave sequence immediately
// [R7] sequence end: idle or rerun on timer
// [R8] writing 11 arms master, waits for touch
// [R9] master repeats on fresh touch or timer
// [R10] host sets channel enables before starting
// [R11] channel codes 7..1 map to inputs
// [R12] bit 9 picks single-ended or ratiometric
// [R13] switch and reference setup per channel
// [R14] pen bit 0: pin shows touch
// [R15] pen bit 1: pin shows limit alert
// [R16] second config register resets to 0x4040
// [R17] settle code selects settling delay
// [R18] settle before X/Y and after sequence
// [R19] interval timer code sets repeat period
// [R20] host idles device before changing setup
// [R21] reading mode after completion returns 00
`timescale 1ns/1ps
module touch_conv_ctrl
    import touch_conv_pkg::*;
#(
    parameter int SETTLE_STEP    = touch_conv_pkg::SETTLE_STEP_CYC,
    parameter int INTERVAL_BASE  = touch_conv_pkg::INTERVAL_BASE_CYC,
    parameter int INTERVAL_STEP  = touch_conv_pkg::INTERVAL_STEP_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    ce,
    input  wire touch_conv_pkg::reg_req_t req,
    output touch_conv_pkg::reg_rsp_t     rsp,
    input  wire logic                    pen_touched,
    input  wire logic                    limit_alert,
    output logic                         irq_pin_n,
    output logic                         conv_start,
    output logic [2:0]                   conv_code,
    output logic                         conv_single_ended,
    input  wire logic                    conv_done,
    input  wire logic [11:0]             conv_data,
    output touch_conv_pkg::sw_ctrl_t     sw_ctrl,
    output logic                         busy
);
    import touch_conv_pkg::*;

    state_t r_reg;
    state_t r_next;

    // result slot for a channel code; aux and battery share one slot
    function automatic logic [2:0] res_slot(input logic [2:0] c);
        case (c)
            CH_YPOS: res_slot = 3'h0;
            CH_XPOS: res_slot = 3'h1;
            CH_Z1:   res_slot = 3'h2;
            CH_Z2:   res_slot = 3'h3;
            CH_TEMP: res_slot = 3'h5;
            default: res_slot = 3'h4;
        endcase
    endfunction : res_slot

    // switch and reference setup for one channel
    function automatic sw_ctrl_t sw_decode(input logic [2:0] c, input logic se);
        sw_ctrl_t s;
        s = '0;
        s.ref_sel = REF_SUPPLY;
        case (c)
            CH_YPOS: begin
                s.yp_on = 1'b1;
                s.yn_on = 1'b1;
                if (!se) s.ref_sel = REF_Y_AXIS;
            end
            CH_XPOS: begin
                s.xp_on = 1'b1;
                s.xn_on = 1'b1;
                if (!se) s.ref_sel = REF_X_AXIS;
            end
            CH_Z1, CH_Z2: begin
                // single-ended pressure reads drive nothing
                s.xn_on = !se;
                s.yp_on = !se;
                if (!se) s.ref_sel = REF_YP_XN;
            end
            default: s.ref_sel = REF_SUPPLY;
        endcase
        sw_decode = s;
    endfunction : sw_decode

    // begin a run for the mode now held in cfg1
    function automatic state_t launch(input state_t s);
        state_t t;
        t = s;
        t.first = 1'b1;
        // a restart never inherits a start pulse from the old run
        t.conv_start = 1'b0; // R1
        case (mode_t'(s.cfg1[MODE_LO +: 2]))
            MODE_SINGLE: begin
                // code 000 leaves only bit 0, which is never converted
                t.mask = 8'h01 << s.cfg1[CHAN_LO +: 3]; // R3 R11
                t.st   = ST_NEXT;
            end
            MODE_SEQ: begin
                t.mask = s.cfg3[7:0] & 8'hFE; // R6 R10
                t.st   = ST_NEXT;
            end
            MODE_MASTER: begin
                t.touch_wait = 1'b1; // R8
                t.released   = 1'b1;
                t.st         = ST_IDLE;
            end
            default: begin
                t.touch_wait = 1'b0; // R1
                t.st         = ST_IDLE;
            end
        endcase
        launch = t;
    endfunction : launch

    logic [2:0]       pick;
    logic [CNT_W-1:0] settle_cyc;
    logic [CNT_W-1:0] interval_cyc;
    logic [7:0]       tmr;
    mode_t            mode;

    // highest enabled channel goes first
    always_comb begin
        pick = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (r_reg.mask[i]) pick = 3'(i);
        end
    end

    assign tmr  = r_reg.cfg1[TMR_LO +: 8];
    assign mode = mode_t'(r_reg.cfg1[MODE_LO +: 2]); // R2
    assign settle_cyc =
        CNT_W'(settle_steps(r_reg.cfg2[SETTLE_LO +: 4]) * SETTLE_STEP); // R17
    assign interval_cyc =
        CNT_W'(INTERVAL_BASE + (int'(tmr) - 1) * INTERVAL_STEP); // R19

    // sequencing, register port and pin selection
    always_comb begin
        r_next = r_reg;
        r_next.conv_start = 1'b0;
        r_next.rvalid     = 1'b0;
        r_next.irq_n = r_reg.cfg1[PEN_DIS_BIT] ? !limit_alert : !pen_touched; // R14 R15
        case (r_reg.st)
            ST_IDLE: begin
                // master arm: needs a touch after the last release; the write of 11 counts as a release, so a touch held then starts at once
                if (r_reg.touch_wait) begin
                    if (!pen_touched) begin
                        r_next.released = 1'b1;
                    end else if (r_reg.released) begin
                        r_next.mask       = r_reg.cfg3[7:0] & 8'hFE; // R9
                        r_next.first      = 1'b1;
                        r_next.touch_wait = 1'b0;
                        r_next.st         = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                if (r_reg.mask[7:1] == 7'h00) begin
                    r_next.cnt = settle_cyc; // R18
                    r_next.st  = ST_POST;
                end else begin
                    r_next.code = pick;
                    if (r_reg.first || pick == CH_YPOS || pick == CH_XPOS) begin
                        r_next.cnt = settle_cyc; // R18
                        r_next.st  = ST_SETTLE;
                    end else begin
                        r_next.st = ST_CONV;
                    end
                end
            end
            ST_SETTLE: begin
                if (r_reg.cnt <= CNT_W'(1)) r_next.st = ST_CONV;
                else r_next.cnt = r_reg.cnt - CNT_W'(1);
            end
            ST_CONV: begin
                r_next.conv_start = 1'b1;
                r_next.st         = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    r_next.res[res_slot(r_reg.code)] = conv_data; // R6
                    r_next.mask[r_reg.code]          = 1'b0;
                    r_next.first                     = 1'b0;
                    r_next.st                        = ST_NEXT;
                end
            end
            ST_POST: begin
                // precharge time for the pen-detect line
                if (r_reg.cnt <= CNT_W'(1)) r_next.st = ST_END;
                else r_next.cnt = r_reg.cnt - CNT_W'(1);
            end
            ST_END: begin
                if (mode == MODE_MASTER) begin
                    if (tmr != 8'h00 && pen_touched) begin
                        r_next.cnt = interval_cyc; // R9
                        r_next.st  = ST_TIMER;
                    end else begin
                        r_next.touch_wait = 1'b1;
                        r_next.released   = !pen_touched;
                        r_next.st         = ST_IDLE;
                    end
                end else if (tmr == 8'h00) begin
                    r_next.cfg1[MODE_LO +: 2] = MODE_IDLE; // R4 R7 R21
                    r_next.st                 = ST_IDLE;
                end else begin
                    r_next.cnt = interval_cyc; // R5 R7
                    r_next.st  = ST_TIMER;
                end
            end
            ST_TIMER: begin
                if (mode == MODE_MASTER && !pen_touched) begin
                    // release stops the timer; next touch restarts at once
                    r_next.touch_wait = 1'b1;
                    r_next.released   = 1'b1;
                    r_next.st         = ST_IDLE;
                end else if (r_reg.cnt <= CNT_W'(1)) begin
                    // relaunch from r_next so read strobe and pin keep this cycle's values
                    r_next = launch(r_next); // R5 R7
                    if (mode == MODE_MASTER) begin
                        r_next.touch_wait = 1'b0;
                        r_next.mask       = r_reg.cfg3[7:0] & 8'hFE; // R9
                        r_next.st         = ST_NEXT;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - CNT_W'(1);
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
        // host write beats the automatic mode clear in the same cycle
        if (req.wr) begin
            case (req.addr)
                ADDR_CFG1: begin
                    r_next.cfg1 = req.wdata;
                    r_next      = launch(r_next); // R6 R8 R20
                end
                ADDR_CFG2: r_next.cfg2 = req.wdata; // R12
                ADDR_CFG3: r_next.cfg3 = req.wdata;
                default: ;
            endcase
        end
        if (req.rd) begin
            r_next.rvalid = 1'b1;
            case (req.addr)
                ADDR_CFG1: r_next.rdata = r_reg.cfg1; // R21
                ADDR_CFG2: r_next.rdata = r_reg.cfg2;
                ADDR_CFG3: r_next.rdata = r_reg.cfg3;
                default: begin
                    if (req.addr >= ADDR_RES_BASE && req.addr <= ADDR_RES_LAST)
                        r_next.rdata = {4'h0, r_reg.res[3'(req.addr - ADDR_RES_BASE)]};
                    else
                        r_next.rdata = 16'h0000;
                end
            endcase
        end
    end

    // single state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            r_reg       <= '0;
            r_reg.st    <= ST_IDLE;
            r_reg.cfg1  <= CFG1_RST;
            r_reg.cfg2  <= CFG2_RST; // R16
            r_reg.cfg3  <= CFG3_RST;
            r_reg.irq_n <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign rsp.rvalid        = r_reg.rvalid;
    assign rsp.rdata         = r_reg.rdata;
    assign irq_pin_n         = r_reg.irq_n;
    assign conv_start        = r_reg.conv_start;
    assign conv_code         = r_reg.code;
    assign conv_single_ended = r_reg.cfg2[SE_BIT]; // R12
    assign sw_ctrl = (r_reg.st == ST_SETTLE || r_reg.st == ST_CONV || r_reg.st == ST_WAIT)
                     ? sw_decode(r_reg.code, r_reg.cfg2[SE_BIT]) : '0; // R13
    assign busy = r_reg.st != ST_IDLE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic wr_cfg1;
    assign wr_cfg1 = ce && req.wr && req.addr == ADDR_CFG1;

    sequence end_single_s;
        ce && r_reg.st == ST_END && mode == MODE_SINGLE && !wr_cfg1;
    endsequence
    sequence arm_master_s;
        wr_cfg1 && req.wdata[MODE_LO +: 2] == MODE_MASTER;
    endsequence
    sequence end_seq_s;
        ce && r_reg.st == ST_END && mode == MODE_SEQ && !wr_cfg1;
    endsequence

    mode_zero_idle_a: assert property ( // R1
        mode == MODE_IDLE |-> r_reg.st == ST_IDLE && !conv_start && !r_reg.touch_wait)
        else $error("conversion activity while mode is idle");
    single_chan_a: assert property ( // R3
        conv_start && mode == MODE_SINGLE |-> conv_code == r_reg.cfg1[CHAN_LO +: 3])
        else $error("single conversion on wrong channel");
    auto_clear_a: assert property ( // R4
        end_single_s and tmr == 8'h00 |=> mode == MODE_IDLE && r_reg.st == ST_IDLE)
        else $error("mode not cleared after single conversion");
    repeat_single_a: assert property ( // R5
        end_single_s and tmr != 8'h00 |=> mode == MODE_SINGLE && r_reg.st == ST_TIMER
            && r_reg.cnt == $past(interval_cyc))
        else $error("single conversion not rescheduled");
    seq_start_a: assert property ( // R6
        wr_cfg1 && req.wdata[MODE_LO +: 2] == MODE_SEQ |=> r_reg.st == ST_NEXT
            && r_reg.mask == ($past(r_reg.cfg3[7:0]) & 8'hFE))
        else $error("slave sequence did not start at once");
    master_arm_a: assert property ( // R8
        arm_master_s ##1 (!pen_touched && ce) |=> r_reg.st == ST_IDLE && !conv_start)
        else $error("master mode converted without touch");
    pen_pin_a: assert property ( // R14
        ce && !r_reg.cfg1[PEN_DIS_BIT] && !wr_cfg1 |=> irq_pin_n == !$past(pen_touched))
        else $error("pen pin does not follow touch");
    limit_pin_a: assert property ( // R15
        ce && r_reg.cfg1[PEN_DIS_BIT] && !wr_cfg1 |=> irq_pin_n == !$past(limit_alert))
        else $error("pin does not follow limit alert");
    pressure_sw_a: assert property ( // R13
        r_reg.st == ST_CONV && conv_code == CH_Z1 && !r_reg.cfg2[SE_BIT]
            |-> sw_ctrl.xn_on && sw_ctrl.yp_on && sw_ctrl.ref_sel == REF_YP_XN)
        else $error("pressure switch setup wrong");
    settle_load_a: assert property ( // R17
        ce && r_reg.st == ST_NEXT && r_reg.first && r_reg.mask[7:1] != 7'h00 && !req.wr
            |=> r_reg.st == ST_SETTLE && r_reg.cnt == $past(settle_cyc))
        else $error("settle delay not loaded");
    seq_clear_a: assert property ( // R7
        end_seq_s and tmr == 8'h00 |=> mode == MODE_IDLE && r_reg.st == ST_IDLE)
        else $error("mode not cleared after sequence");
    master_rerun_a: assert property ( // R9
        ce && r_reg.st == ST_END && mode == MODE_MASTER && tmr != 8'h00 && pen_touched
            && !wr_cfg1 |=> r_reg.st == ST_TIMER && r_reg.cnt == $past(interval_cyc))
        else $error("master rerun timer not loaded");
endmodule : touch_conv_ctrl

// File: design/touch_conv_pkg.sv
// constants, types and state layout for the touch converter conversion controller
// assumes a 50 MHz core clock and a 16-bit register port in front of it
package touch_conv_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CFG1     = 8'h01;
    localparam logic [7:0] ADDR_CFG2     = 8'h02;
    localparam logic [7:0] ADDR_CFG3     = 8'h03;
    localparam logic [7:0] ADDR_RES_BASE = 8'h08;
    localparam logic [7:0] ADDR_RES_LAST = 8'h0D;
    // field positions
    localparam int TMR_LO      = 0;
    localparam int SE_BIT      = 9;
    localparam int MODE_LO     = 10;
    localparam int CHAN_LO     = 12;
    localparam int PEN_DIS_BIT = 15;
    localparam int SETTLE_LO   = 0;
    // reset values
    localparam logic [15:0] CFG1_RST = 16'h0000;
    localparam logic [15:0] CFG2_RST = 16'h4040;
    localparam logic [15:0] CFG3_RST = 16'h0000;
    // timing
    localparam int CLK_MHZ           = 50;
    localparam int SETTLE_STEP_US    = 128;
    localparam int INTERVAL_BASE_US  = 550;
    localparam int INTERVAL_STEP_US  = 35;
    localparam int SETTLE_STEP_CYC   = SETTLE_STEP_US * CLK_MHZ;
    localparam int INTERVAL_BASE_CYC = INTERVAL_BASE_US * CLK_MHZ;
    localparam int INTERVAL_STEP_CYC = INTERVAL_STEP_US * CLK_MHZ;
    localparam int CNT_W             = 20;
    // channel codes
    localparam logic [2:0] CH_YPOS = 3'h7;
    localparam logic [2:0] CH_XPOS = 3'h6;
    localparam logic [2:0] CH_Z1   = 3'h5;
    localparam logic [2:0] CH_Z2   = 3'h4;
    localparam logic [2:0] CH_AUX  = 3'h3;
    localparam logic [2:0] CH_BAT  = 3'h2;
    localparam logic [2:0] CH_TEMP = 3'h1;

    typedef enum logic [1:0] {
        MODE_IDLE   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_SEQ    = 2'b10,
        MODE_MASTER = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        REF_SUPPLY = 2'b00,
        REF_Y_AXIS = 2'b01,
        REF_X_AXIS = 2'b10,
        REF_YP_XN  = 2'b11
    } ref_sel_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_NEXT   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONV   = 3'b011,
        ST_WAIT   = 3'b100,
        ST_POST   = 3'b101,
        ST_END    = 3'b110,
        ST_TIMER  = 3'b111
    } st_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic     xp_on;
        logic     xn_on;
        logic     yp_on;
        logic     yn_on;
        ref_sel_t ref_sel;
    } sw_ctrl_t;

    typedef struct packed {
        st_t               st;
        logic              touch_wait;
        logic              released;
        logic [15:0]       cfg1;
        logic [15:0]       cfg2;
        logic [15:0]       cfg3;
        logic [5:0][11:0]  res;
        logic [CNT_W-1:0]  cnt;
        logic [7:0]        mask;
        logic [2:0]        code;
        logic              first;
        logic              conv_start;
        logic              irq_n;
        logic              rvalid;
        logic [15:0]       rdata;
    } state_t;

    // settle delay in 128 us steps per code
    function automatic int settle_steps(input logic [3:0] c);
        case (c)
            4'hA:    settle_steps = 12;
            4'hB:    settle_steps = 14;
            4'hC:    settle_steps = 16;
            4'hD:    settle_steps = 20;
            4'hE:    settle_steps = 28;
            4'hF:    settle_steps = 32;
            default: settle_steps = int'(c) + 1;
        endcase
    endfunction : settle_steps
endpackage : touch_conv_pkg

// File: test/sar_model.sv
// behavioural converter core facing the conversion controller
// assumes conv_start is a one-cycle pulse; lat sets the answer delay
`timescale 1ns/1ps
module sar_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_code,
    input  wire logic [3:0]  lat,
    output logic             conv_done,
    output logic [11:0]      conv_data
);
    logic [3:0] left_reg;
    logic       run_reg;
    logic [2:0] code_reg;
    // answer lat+1 cycles after a start; data toggles outside the done pulse
    // so a controller sampling at the wrong time picks up garbage
    always_ff @(posedge clk) begin
        if (srst) begin
            run_reg <= 1'b0;
            left_reg <= 4'h0;
            code_reg <= 3'h0;
            conv_done <= 1'b0;
            conv_data <= 12'hFFF;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start) begin
                run_reg <= 1'b1;
                left_reg <= lat;
                code_reg <= conv_code;
            end else if (run_reg && left_reg == 4'h0) begin
                run_reg <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {code_reg, 9'h0A5};
            end else if (run_reg) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end
endmodule : sar_model

// File: test/touch_adc_conversion_control_bench.sv
// self-checking bench for the conversion controller with a converter model
// assumes short timing parameters; inputs change on the falling edge
`timescale 1ns/1ps
module touch_adc_conversion_control_bench;
    import touch_conv_pkg::*;
    localparam int STEP = 4;
    logic        clk, srst, ce, pen_touched, limit_alert, irq_pin_n, busy;
    logic        conv_start, conv_single_ended, conv_done;
    logic [2:0]  conv_code;
    logic [11:0] conv_data;
    logic [3:0]  lat;
    reg_req_t    req;
    reg_rsp_t    rsp;
    sw_ctrl_t    sw_ctrl;
    int          fails, n_checks;
    logic [2:0]  codes[$];
    sw_ctrl_t    sws[$];
    logic        ses[$];

    touch_conv_ctrl #(.SETTLE_STEP(STEP), .INTERVAL_BASE(20), .INTERVAL_STEP(2))
        touch_conv_ctrl_inst (.clk, .srst, .ce, .req, .rsp, .pen_touched, .limit_alert,
        .irq_pin_n, .conv_start, .conv_code, .conv_single_ended, .conv_done, .conv_data,
        .sw_ctrl, .busy);
    sar_model sar_model_inst (.clk, .srst, .conv_start, .conv_code, .lat, .conv_done,
        .conv_data);

    // clock, and a log of every conversion launched
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            codes.push_back(conv_code);
            sws.push_back(sw_ctrl);
            ses.push_back(conv_single_ended);
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // register port helpers; all enter and leave on a falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        // let an edge pass so a following write never re-raises wr in this step
        @(negedge clk);
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        for (int i = 0; i < 4 && rsp.rvalid !== 1'b1; i++) @(negedge clk);
        chk(what, rsp.rvalid === 1'b1 ? rsp.rdata : 16'hDEAD, exp);
        @(negedge clk);
    endtask : rchk
    // bounded wait for a start pulse or for the sequencer to go idle
    task automatic wait_for(input bit idle, input int lim, output int n);
        n = 0;
        while ((idle ? ~busy : conv_start) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("[ERR] wait expected event seen timeout");
            summarize();
        end
    endtask : wait_for
    task automatic run_idle(input int lim);
        int n;
        repeat (3) @(negedge clk);
        wait_for(1'b1, lim, n);
        repeat (2) @(negedge clk);
    endtask : run_idle
    function automatic logic [15:0] res(input logic [2:0] c);
        res = {4'h0, c, 9'h0A5};
    endfunction : res

    task automatic t_reset;
        rchk("cfg1", ADDR_CFG1, 16'h0000);
        rchk("cfg2", ADDR_CFG2, 16'h4040);
        rchk("cfg3", ADDR_CFG3, 16'h0000);
        rchk("unmapped", 8'h20, 16'h0000);
        wr(8'h08, 16'hFFFF);
        rchk("result ro", 8'h08, 16'h0000);
        repeat (50) @(negedge clk);
        chk("idle starts", 16'(codes.size()), 16'h0);
        chk("idle irq", {15'h0, irq_pin_n}, 16'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_single;
        codes.delete();
        sws.delete();
        wr(ADDR_CFG1, 16'h5400);
        run_idle(300);
        chk("single count", 16'(codes.size()), 16'h1);
        chk("single code", {13'h0, codes[0]}, 16'h5);
        chk("z1 switches", {10'h0, sws[0]}, {10'h0, 1'b0, 1'b1, 1'b1, 1'b0, REF_YP_XN});
        chk("single ratio", {15'h0, ses[0]}, 16'h0);
        rchk("z1 result", 8'h0A, res(3'h5));
        rchk("mode cleared", ADDR_CFG1, 16'h5000);
        $display("test single done");
    endtask : t_single

    task automatic t_slave;
        codes.delete();
        sws.delete();
        ses.delete();
        lat = 4'h9;
        wr(ADDR_CFG3, 16'h00C2);
        wr(ADDR_CFG2, 16'h4240);
        wr(ADDR_CFG1, 16'h0800);
        run_idle(600);
        chk("seq count", 16'(codes.size()), 16'h3);
        chk("seq order", {7'h00, codes[0], codes[1], codes[2]}, 16'h01F1);
        chk("ypos switches", {10'h0, sws[0]}, {10'h0, 4'b0011, REF_SUPPLY});
        chk("xpos switches", {10'h0, sws[1]}, {10'h0, 4'b1100, REF_SUPPLY});
        chk("seq single", {13'h0, ses[0], ses[1], ses[2]}, 16'h7);
        rchk("ypos result", 8'h08, res(3'h7));
        rchk("xpos result", 8'h09, res(3'h6));
        rchk("temp result", 8'h0D, res(3'h1));
        rchk("seq cleared", ADDR_CFG1, 16'h0000);
        $display("test slave done");
    endtask : t_slave

    task automatic t_settle;
        logic [3:0] fc [4];
        int         st [4];
        int         n;
        fc = '{4'h0, 4'h9, 4'hA, 4'hF};
        st = '{1, 10, 12, 32};
        lat = 4'h1;
        wr(ADDR_CFG3, 16'h0002);
        foreach (fc[k]) begin
            wr(ADDR_CFG2, 16'h4040 | {12'h000, fc[k]});
            wr(ADDR_CFG1, 16'h0800);
            wait_for(1'b0, 300, n);
            chk("first delay", 16'(n >= st[k] * STEP && n <= st[k] * STEP + 4), 16'h1);
            wait_for(1'b1, 300, n);
            chk("precharge", 16'(n >= st[k] * STEP), 16'h1);
            repeat (3) @(negedge clk);
        end
        $display("test settle done");
    endtask : t_settle

    task automatic t_timer;
        wr(ADDR_CFG2, 16'h4040);
        codes.delete();
        wr(ADDR_CFG1, 16'h1401);
        repeat (400) @(negedge clk);
        chk("repeats", 16'(codes.size() >= 3), 16'h1);
        rchk("mode kept", ADDR_CFG1, 16'h1401);
        wr(ADDR_CFG1, 16'h0000);
        run_idle(300);
        codes.delete();
        repeat (300) @(negedge clk);
        chk("stopped", 16'(codes.size()), 16'h0);
        $display("test timer done");
    endtask : t_timer

    task automatic t_master;
        int n;
        codes.delete();
        wr(ADDR_CFG1, 16'h0C00);
        repeat (200) @(negedge clk);
        chk("armed no start", 16'(codes.size()), 16'h0);
        chk("untouched irq", {15'h0, irq_pin_n}, 16'h1);
        pen_touched = 1'b1;
        repeat (2) @(negedge clk);
        chk("touched irq", {15'h0, irq_pin_n}, 16'h0);
        wait_for(1'b0, 100, n);
        run_idle(300);
        repeat (300) @(negedge clk);
        chk("held no rerun", 16'(codes.size()), 16'h1);
        pen_touched = 1'b0;
        repeat (50) @(negedge clk);
        pen_touched = 1'b1;
        wait_for(1'b0, 100, n);
        run_idle(300);
        chk("fresh touch", 16'(codes.size()), 16'h2);
        // master with timer: reruns while held, stops on release
        codes.delete();
        wr(ADDR_CFG1, 16'h0C01);
        repeat (200) @(negedge clk);
        chk("timer rerun", 16'(codes.size() >= 3), 16'h1);
        pen_touched = 1'b0;
        run_idle(300);
        codes.delete();
        repeat (100) @(negedge clk);
        chk("release stops", 16'(codes.size()), 16'h0);
        pen_touched = 1'b1;
        wr(ADDR_CFG1, 16'h8000);
        repeat (3) @(negedge clk);
        chk("pen masked", {15'h0, irq_pin_n}, 16'h1);
        limit_alert = 1'b1;
        repeat (2) @(negedge clk);
        chk("limit irq", {15'h0, irq_pin_n}, 16'h0);
        $display("test master done");
    endtask : t_master

    // main sequence and a watchdog that ends a hang
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        req = '0;
        pen_touched = 1'b0;
        limit_alert = 1'b0;
        lat = 4'h2;
        fails = 0;
        n_checks = 0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_single();
        t_slave();
        t_settle();
        t_timer();
        t_master();
        summarize();
    end
    initial begin
        #1500000;
        fails++;
        summarize();
    end
endmodule : touch_adc_conversion_control_bench
